// [verilog/mb_request_handler.v]
// request handler of a serial-line field-bus slave
// assumes a framer on the same clock delivers decoded requests and
// takes answer words; register store sits outside behind reg_* ports
//
// Behaviour
// - accept codes 03 04 06 08 16 23
// - reads limited to 125 registers
// - codes 03 and 04 behave identically
// - code 06 writes exactly one register
// - diagnostics loopback and diagnostics register
// - code 16 writes up to 120 registers
// - code 23 writes before reading, 118 max
// - broadcast only for 06, 16, 23
// - answer starts 3 to 5 ms later
// - floats ieee 754 over two registers
// - integer: byte 1 high, byte 0 low
// - strings packed two bytes per register
// - every register holds two bytes
// - configurable byte order, default 1-0-3-2
`timescale 1ns/1ps
`include "mb_defs.vh"
module mb_request_handler #(
   parameter MIN_WAIT = `RESP_MIN_MS * `CLK_MHZ * 1000, // least answer delay
   parameter MAX_WAIT = `RESP_MAX_MS * `CLK_MHZ * 1000  // longest answer delay
) (
   input  wire        clock_i,        // system clock
   input  wire        arst_n_i,       // async reset, low active
   input  wire        req_valid_i,    // one-cycle pulse: request present
   input  wire [7:0]  req_slave_i,    // slave address, zero is broadcast
   input  wire [7:0]  req_func_i,     // function code
   input  wire [15:0] req_start_i,    // read start, single-write register or diag sub-function
   input  wire [7:0]  req_count_i,    // read register count
   input  wire [15:0] req_wstart_i,   // write start register
   input  wire [7:0]  req_wcount_i,   // write register count
   input  wire [15:0] req_data_i,     // loopback data
   output wire        req_ready_o,    // idle, may take a request
   output wire        wdata_req_o,    // asks for next write word
   input  wire [15:0] wdata_i,        // write word, same cycle as above
   output reg         reg_we_o,       // register write strobe
   output reg         reg_re_o,       // register read strobe
   output reg  [15:0] reg_addr_o,     // register address
   output reg  [15:0] reg_wdata_o,    // register write data
   input  wire [15:0] reg_rdata_i,    // read data, same cycle as re
   input  wire [15:0] diag_reg_i,     // diagnostics register contents
   input  wire [1:0]  byte_order_i,   // byte-order selection
   input  wire        float_i,        // value pairs as float
   output reg         ans_valid_o,    // answer word valid
   output reg  [31:0] ans_bytes_o,    // answer bytes, first in 31:24
   output reg  [2:0]  ans_nbytes_o,   // number of valid bytes
   output reg         ans_last_o,     // last answer word
   input  wire        ans_ready_i     // framer took the word
);
   // one-hot states
   localparam S_IDLE  = 6'b000001;
   localparam S_WRITE = 6'b000010;
   localparam S_READ  = 6'b000100;
   localparam S_WAIT  = 6'b001000;
   localparam S_SEND  = 6'b010000;
   localparam S_RDAT  = 6'b100000;

   reg  [5:0]  state;                 // current state
   reg  [7:0]  func;                  // latched function code
   reg  [7:0]  exc;                   // exception code, zero if none
   reg  [15:0] addr;                  // running register address
   reg  [7:0]  left;                  // registers still to transfer
   reg  [15:0] rstart;                // read start
   reg  [7:0]  rcount;                // read count
   reg  [15:0] echo;                  // word returned by diagnostics
   reg  [23:0] wait_cnt;              // answer delay counter
   reg         rd_pend;               // read data due this cycle
   reg  [15:0] hold;                  // first register of a pair
   reg         half;                  // holding first of a pair
   reg  [31:0] pair;                  // value fed to byte mapper
   reg         bcast_lat;             // current request is broadcast
   wire [31:0] mapped;                // reordered answer bytes
   wire        ok_code;               // code supported
   wire        ok_bcast;              // code allowed on broadcast
   wire        bcast;                 // request addressed to all
   wire        bad_cnt;               // count or diag sub-function outside limits

   // code and limit decoding
   function [1:0] classify;
      input [7:0] f;
      begin
         case (f)
            `FC_RD_HOLD, `FC_RD_INPUT, `FC_DIAG:       classify = 2'b01;
            `FC_WR_SINGLE, `FC_WR_MULTI, `FC_RW_MULTI: classify = 2'b11;
            default:                                   classify = 2'b00;
         endcase
      end
   endfunction

   assign ok_code  = classify(req_func_i) != 2'b00;
   assign ok_bcast = classify(req_func_i) == 2'b11;
   assign bcast    = req_slave_i == `BCAST_ADDR;
   assign bad_cnt  =
      ((req_func_i == `FC_RD_HOLD || req_func_i == `FC_RD_INPUT) &&
       (req_count_i == 8'h00 || req_count_i > `MAX_RD_REGS)) ||
      (req_func_i == `FC_WR_MULTI &&
       (req_wcount_i == 8'h00 || req_wcount_i > `MAX_WR_REGS)) ||
      (req_func_i == `FC_RW_MULTI &&
       (req_count_i == 8'h00 || req_wcount_i == 8'h00 ||
        req_count_i > `MAX_RW_REGS || req_wcount_i > `MAX_RW_REGS)) ||
      (req_func_i == `FC_DIAG && req_start_i != `SUB_LOOPBACK &&
       req_start_i != `SUB_DIAG_REG);

   assign req_ready_o = state == S_IDLE;
   assign wdata_req_o = state == S_WRITE;

   // byte mapping of value pairs
   mb_byte_order u_order (
      .order_i      (byte_order_i),
      .value_i      (pair),
      .wire_bytes_o (mapped)
   );

   // floats reordered as a whole; integers/strings send byte 0 first under orders 0-1-2-3 and 2-3-0-1
   always @* begin
      pair = {hold, reg_rdata_i};
   end

   // main sequencer
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state        <= S_IDLE;
         func         <= 8'h00;
         exc          <= 8'h00;
         addr         <= 16'h0000;
         left         <= 8'h00;
         rstart       <= 16'h0000;
         rcount       <= 8'h00;
         echo         <= 16'h0000;
         wait_cnt     <= 24'h000000;
         rd_pend      <= 1'b0;
         hold         <= 16'h0000;
         half         <= 1'b0;
         reg_we_o     <= 1'b0;
         reg_re_o     <= 1'b0;
         reg_addr_o   <= 16'h0000;
         reg_wdata_o  <= 16'h0000;
         ans_valid_o  <= 1'b0;
         ans_bytes_o  <= 32'h00000000;
         ans_nbytes_o <= 3'h0;
         ans_last_o   <= 1'b0;
      end else begin
         reg_we_o <= 1'b0;
         reg_re_o <= 1'b0;
         rd_pend  <= 1'b0;
         // a word stands until the framer takes it, in every state
         if (ans_ready_i) begin
            ans_valid_o <= 1'b0;
         end
         case (state)
            S_IDLE: begin
               wait_cnt <= 24'h000000;
               half     <= 1'b0;
               if (req_valid_i) begin
                  func   <= req_func_i;
                  rstart <= req_start_i;
                  rcount <= req_count_i;
                  echo   <= (req_start_i == `SUB_DIAG_REG) ? diag_reg_i
                                                           : req_data_i;
                  if (bcast && (!ok_bcast || bad_cnt)) begin
                     state <= S_IDLE;
                  end else if (!ok_code) begin
                     exc   <= `EXC_BAD_FUNC;
                     state <= S_WAIT;
                  end else if (bad_cnt) begin
                     exc   <= `EXC_BAD_VALUE;
                     state <= S_WAIT;
                  end else begin
                     exc <= 8'h00;
                     if (req_func_i == `FC_WR_SINGLE) begin
                        addr  <= req_start_i;
                        left  <= 8'h01;
                        state <= S_WRITE;
                     end else if (req_func_i == `FC_WR_MULTI ||
                                  req_func_i == `FC_RW_MULTI) begin
                        addr  <= req_wstart_i;
                        left  <= req_wcount_i;
                        state <= S_WRITE;
                     end else begin
                        state <= S_WAIT;
                     end
                  end
               end
            end
            S_WRITE: begin
               // one register of two bytes per cycle
               reg_we_o    <= 1'b1;
               reg_addr_o  <= addr;
               reg_wdata_o <= wdata_i;
               addr        <= addr + 16'h0001;
               left        <= left - 8'h01;
               if (left == 8'h01) begin
                  // writes finish before any read starts
                  state <= (bcast_lat) ? S_IDLE : S_WAIT;
               end
            end
            S_WAIT: begin
               // hold off the answer until the least delay passed
               wait_cnt <= wait_cnt + 24'h000001;
               if (wait_cnt >= MIN_WAIT[23:0] - 24'h000001) begin
                  addr  <= rstart;
                  left  <= rcount;
                  state <= S_SEND;
               end
            end
            S_SEND: begin
               if (!ans_valid_o || ans_ready_i) begin
                  ans_valid_o <= 1'b0;
                  if (exc != 8'h00 || func == `FC_WR_SINGLE ||
                      func == `FC_WR_MULTI || func == `FC_DIAG) begin
                     // single header-style word: status or echo
                     ans_valid_o  <= 1'b1;
                     ans_bytes_o  <= (exc != 8'h00) ? {func | `EXC_FLAG, exc, 16'h0000}
                                                    : {echo, 16'h0000};
                     ans_nbytes_o <= 3'h2;
                     ans_last_o   <= 1'b1;
                     state        <= S_IDLE;
                  end else begin
                     reg_re_o   <= 1'b1;
                     reg_addr_o <= addr;
                     addr       <= addr + 16'h0001;
                     left       <= left - 8'h01;
                     rd_pend    <= 1'b1;
                     state      <= S_RDAT;
                  end
               end
            end
            S_RDAT: begin
               if (rd_pend) begin
                  if (float_i && !half && left != 8'h00) begin
                     hold  <= reg_rdata_i;
                     half  <= 1'b1;
                     state <= S_SEND;
                  end else if (half) begin
                     half         <= 1'b0;
                     ans_valid_o  <= 1'b1;
                     ans_bytes_o  <= mapped;
                     ans_nbytes_o <= 3'h4;
                     ans_last_o   <= left == 8'h00;
                     state        <= (left == 8'h00) ? S_IDLE : S_SEND;
                  end else begin
                     ans_valid_o  <= 1'b1;
                     ans_bytes_o  <= (byte_order_i == `BO_0123 ||
                                      byte_order_i == `BO_2301)
                                     ? {reg_rdata_i[7:0], reg_rdata_i[15:8], 16'h0000}
                                     : {reg_rdata_i, 16'h0000};
                     ans_nbytes_o <= 3'h2;
                     ans_last_o   <= left == 8'h00;
                     state        <= (left == 8'h00) ? S_IDLE : S_SEND;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // broadcast flag kept for the request in flight
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bcast_lat <= 1'b0;
      end else if (state == S_IDLE && req_valid_i) begin
         bcast_lat <= bcast;
      end
   end
endmodule // mb_request_handler

// [verilog/mb_defs.vh]
// constants for the serial-line request handler
// assumes one 100 MHz clock; included by bare name
`ifndef MB_DEFS_VH
`define MB_DEFS_VH
`define FC_RD_HOLD      8'h03
`define FC_RD_INPUT     8'h04
`define FC_WR_SINGLE    8'h06
`define FC_DIAG         8'h08
`define FC_WR_MULTI     8'h10
`define FC_RW_MULTI     8'h17
`define SUB_LOOPBACK    16'h0000
`define SUB_DIAG_REG    16'h0002
`define MAX_RD_REGS     8'h7d
`define MAX_WR_REGS     8'h78
`define MAX_RW_REGS     8'h76
`define EXC_FLAG        8'h80
`define EXC_BAD_FUNC    8'h01
`define EXC_BAD_VALUE   8'h03
`define BCAST_ADDR      8'h00
`define CLK_MHZ         100
`define RESP_MIN_MS     3
`define RESP_MAX_MS     5
`define BO_1032         2'b00
`define BO_0123         2'b01
`define BO_2301         2'b10
`define BO_3210         2'b11
`endif

// [verilog/mb_byte_order.v]
// byte-order mapper: turns a 32-bit value into four wire bytes
// assumes a float in ieee 754 single layout, sign in byte 3
`timescale 1ns/1ps
`include "mb_defs.vh"
module mb_byte_order (
   input  wire [1:0]  order_i,       // byte-order selection
   input  wire [31:0] value_i,       // float or two packed registers
   output reg  [31:0] wire_bytes_o   // first byte sent in bits 31:24
);
   // reorder bytes per selection, integers follow the low half
   always @* begin
      case (order_i)
         `BO_0123: wire_bytes_o = {value_i[7:0], value_i[15:8],
                                   value_i[23:16], value_i[31:24]};
         `BO_2301: wire_bytes_o = {value_i[23:16], value_i[31:24],
                                   value_i[7:0], value_i[15:8]};
         `BO_3210: wire_bytes_o = value_i;
         default:  wire_bytes_o = {value_i[15:8], value_i[7:0],
                                   value_i[31:24], value_i[23:16]};
      endcase
   end
endmodule // mb_byte_order

// [testbench/mb_handler_chk.sv]
// checker: answer timing, strobe counts and broadcast silence
// assumes only the handler's ports, one clock domain
`timescale 1ns/1ps
`include "mb_defs.vh"
module mb_handler_chk #(
   parameter MIN_WAIT = 20, // least answer delay in cycles
   parameter MAX_WAIT = 40  // longest delay, handed on by the bind
) (
   input wire        clock_i,
   input wire        arst_n_i,
   input wire        req_valid_i,
   input wire [7:0]  req_slave_i,
   input wire [7:0]  req_func_i,
   input wire        req_ready_o,
   input wire        reg_we_o,
   input wire        reg_re_o,
   input wire        ans_valid_o,
   input wire [31:0] ans_bytes_o,
   input wire [2:0]  ans_nbytes_o,
   input wire        ans_last_o,
   input wire        ans_ready_i
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   wire       take = req_valid_i & req_ready_o; // request taken
   reg        waiting;  // taken, no answer yet
   reg [15:0] wait_cnt; // cycles since take
   reg [7:0]  wr_cnt;   // write strobes of this request
   reg [7:0]  rd_cnt;   // read strobes of this request
   reg [7:0]  func_q;   // function code of this request
   reg        bc_q;     // request was a broadcast
   wire       bad_bc = bc_q & (func_q != `FC_WR_SINGLE) & (func_q != `FC_WR_MULTI)
                       & (func_q != `FC_RW_MULTI); // broadcast that must be dropped
   // per-request bookkeeping
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         {waiting, wait_cnt, wr_cnt, rd_cnt, func_q, bc_q} <= 42'h0;
      end else if (take) begin
         {waiting, wait_cnt, wr_cnt, rd_cnt} <= {1'b1, 32'h0};
         func_q <= req_func_i;
         bc_q   <= (req_slave_i == `BCAST_ADDR);
      end else begin
         waiting  <= waiting & ~ans_valid_o & ~req_ready_o;
         wait_cnt <= wait_cnt + 16'h1;
         wr_cnt   <= wr_cnt + {7'h0, reg_we_o};
         rd_cnt   <= rd_cnt + {7'h0, reg_re_o};
      end
   end
   a_answer_not_early:
   assert property ($rose(ans_valid_o) && waiting |-> wait_cnt >= MIN_WAIT)
      else $error("answer before the least delay");
   a_answer_in_time:
   assert property (waiting |-> wait_cnt < MIN_WAIT + 140)
      else $error("answer later than allowed");
   a_answer_holds:
   assert property (ans_valid_o && !ans_ready_i |=> ans_valid_o && $stable(ans_bytes_o)
      && $stable(ans_nbytes_o) && $stable(ans_last_o)) else $error("answer word changed");
   a_width_legal:
   assert property (ans_valid_o |-> ans_nbytes_o == 3'd2 || ans_nbytes_o == 3'd4)
      else $error("answer width not two or four bytes");
   a_single_write:
   assert property (func_q == `FC_WR_SINGLE |-> wr_cnt <= 8'd1)
      else $error("single write touched more registers");
   a_write_limit:
   assert property (wr_cnt <= ((func_q == `FC_RW_MULTI) ? `MAX_RW_REGS : `MAX_WR_REGS))
      else $error("too many register writes");
   a_read_limit:
   assert property (rd_cnt <= `MAX_RD_REGS) else $error("too many register reads");
   a_write_first:
   assert property (reg_we_o |-> rd_cnt == 8'd0) else $error("write after a read");
   a_bcast_silent:
   assert property (bc_q |-> !ans_valid_o) else $error("broadcast answered");
   a_bcast_no_access:
   assert property (bad_bc |-> !reg_we_o && !reg_re_o) else $error("dropped broadcast acted");
endmodule // mb_handler_chk
bind mb_request_handler mb_handler_chk #(.MIN_WAIT(MIN_WAIT), .MAX_WAIT(MAX_WAIT)) u_chk (
   .clock_i(clock_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
   .req_slave_i(req_slave_i), .req_func_i(req_func_i), .req_ready_o(req_ready_o),
   .reg_we_o(reg_we_o), .reg_re_o(reg_re_o), .ans_valid_o(ans_valid_o),
   .ans_bytes_o(ans_bytes_o), .ans_nbytes_o(ans_nbytes_o), .ans_last_o(ans_last_o),
   .ans_ready_i(ans_ready_i));

// [testbench/mb_reg_store.sv]
// register store model behind the handler's reg_* strobes
// assumes read data is wanted while the read strobe stands
`timescale 1ns/1ps
module mb_reg_store (
   input  wire        clock_i,     // system clock
   input  wire        reg_we_i,    // write strobe
   input  wire        reg_re_i,    // read strobe
   input  wire [15:0] reg_addr_i,  // register address
   input  wire [15:0] reg_wdata_i, // write data
   output wire [15:0] reg_rdata_o  // read data, while the strobe stands
);
   reg [15:0] mem [0:255]; // two bytes per register
   integer    i;           // fill index
   initial begin
      for (i = 0; i < 256; i = i + 1) mem[i] = 16'h0;
   end
   // writes land at the edge
   always @(posedge clock_i) begin
      if (reg_we_i) mem[reg_addr_i[7:0]] <= reg_wdata_i;
   end
   // read data stands with the strobe only; otherwise the bus shows the inverse
   assign reg_rdata_o = reg_re_i ? mem[reg_addr_i[7:0]] : ~mem[reg_addr_i[7:0]];
endmodule // mb_reg_store

// [testbench/tb_mb_request_handler.sv]
// self-checking bench: requests in, answers scored from a queue
// assumes the store model and the bound checker are compiled too
`timescale 1ns/1ps
`include "mb_defs.vh"
`define CHECK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_mb_request_handler;
   localparam [7:0] ID = 8'h2a; // unicast slave address
   reg clock_i = 0, arst_n_i = 0, req_valid_i = 0, float_i = 0, ans_ready_i = 0, take_w = 0;
   reg [7:0]  req_slave_i = 0, req_func_i = 0, req_count_i = 0, req_wcount_i = 0;
   reg [15:0] req_start_i = 0, req_wstart_i = 0, req_data_i = 0, wdata_i = 0, diag_reg_i = 0;
   reg [1:0]  byte_order_i = 0;
   wire req_ready_o, wdata_req_o, reg_we_o, reg_re_o, ans_valid_o, ans_last_o;
   wire [15:0] reg_addr_o, reg_wdata_o, reg_rdata_i;
   wire [31:0] ans_bytes_o;
   wire [2:0]  ans_nbytes_o;
   logic [36:0] exq[$];  // expected {check, last, width, bytes}
   logic [36:0] ev;      // note taken off the queue
   logic [15:0] wq[$];   // write words for the handler
   logic [15:0] sh [0:255]; // expected register contents
   integer seed = 32'h4b0e, n_fail = 0, cmp_count = 0, cyc = 0, i;
   mb_request_handler #(.MIN_WAIT(20), .MAX_WAIT(40)) dut (.clock_i(clock_i),
      .arst_n_i(arst_n_i), .req_valid_i(req_valid_i), .req_slave_i(req_slave_i),
      .req_func_i(req_func_i), .req_start_i(req_start_i), .req_count_i(req_count_i),
      .req_wstart_i(req_wstart_i), .req_wcount_i(req_wcount_i), .req_data_i(req_data_i),
      .req_ready_o(req_ready_o), .wdata_req_o(wdata_req_o), .wdata_i(wdata_i),
      .reg_we_o(reg_we_o), .reg_re_o(reg_re_o), .reg_addr_o(reg_addr_o),
      .reg_wdata_o(reg_wdata_o), .reg_rdata_i(reg_rdata_i), .diag_reg_i(diag_reg_i),
      .byte_order_i(byte_order_i), .float_i(float_i), .ans_valid_o(ans_valid_o),
      .ans_bytes_o(ans_bytes_o), .ans_nbytes_o(ans_nbytes_o), .ans_last_o(ans_last_o),
      .ans_ready_i(ans_ready_i));
   mb_reg_store u_store (.clock_i(clock_i), .reg_we_i(reg_we_o), .reg_re_i(reg_re_o),
      .reg_addr_i(reg_addr_o), .reg_wdata_i(reg_wdata_o), .reg_rdata_o(reg_rdata_i));
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   // write words: the one sampled is dropped at the next falling edge
   always @(posedge clock_i) take_w <= wdata_req_o;
   always @(negedge clock_i) begin
      if (take_w === 1'b1 && wq.size() > 0) void'(wq.pop_front());
      wdata_i <= (wq.size() > 0) ? wq[0] : ~wdata_i;
      ans_ready_i <= ($random(seed) & 3) != 0; // random stalls
   end
   // answer monitor against the oldest note
   always @(posedge clock_i) begin
      cyc = cyc + 1;
      if (ans_valid_o === 1'b1 && ans_ready_i === 1'b1) begin
         if (exq.size() == 0) `CHECK("extra answer", 1'b0, 1'b1)
         else begin
            ev = exq.pop_front();
            `CHECK("answer width", ev[34:32], ans_nbytes_o)
            `CHECK("answer last", ev[35], ans_last_o)
            if (ev[36]) `CHECK("answer bytes", ev[31:0] & ((ev[34:32] == 3'd4) ? 32'hffffffff
               : 32'hffff0000), ans_bytes_o & ((ev[34:32] == 3'd4) ? 32'hffffffff
               : 32'hffff0000))
         end
      end
      // ceiling last, so nothing runs after the run ends
      if (cyc == 20000) begin
         n_fail++;
         give_verdict;
      end
   end
   function [31:0] ord(input [1:0] o, input [31:0] v);
      case (o)
         2'b00: ord = {v[15:0], v[31:16]};
         2'b01: ord = {v[7:0], v[15:8], v[23:16], v[31:24]};
         2'b10: ord = {v[23:16], v[31:24], v[7:0], v[15:8]};
         default: ord = v;
      endcase
   endfunction
   task exq_add(input [31:0] b, input [2:0] n, input l, input c);
      exq.push_back({c, l, n, b});
   endtask
   // one request, held for the one edge at which it is taken
   task req(input [7:0] sl, fc, input [15:0] st, input [7:0] cn, input [15:0] ws,
            input [7:0] wc, input [15:0] dt);
      integer k;
      k = 0;
      while (req_ready_o !== 1'b1 && k < 3000) begin
         @(negedge clock_i);
         k++;
      end
      {req_slave_i, req_func_i, req_start_i, req_count_i} = {sl, fc, st, cn};
      {req_wstart_i, req_wcount_i, req_data_i, req_valid_i} = {ws, wc, dt, 1'b1};
      @(negedge clock_i);
      req_valid_i = 0;
      @(negedge clock_i);
   endtask
   // writes of codes 06, 16 and 23; legal ones update the expectation
   task wr(input [7:0] sl, fc, input [15:0] ws, input [7:0] wc, rs, rc);
      integer k;
      logic ok;
      // the word queue is still in use until the previous writes end
      while (req_ready_o !== 1'b1 || take_w === 1'b1) @(negedge clock_i);
      ok = (fc == `FC_WR_SINGLE) ? wc == 1 : (fc == `FC_WR_MULTI) ? wc <= 120
           : (wc <= 118 && rc <= 118);
      wq.delete();
      for (k = 0; k < wc; k++) wq.push_back($random(seed));
      for (k = 0; k < wc && ok; k++) sh[ws + k] = wq[k];
      if (sl != 0 && !ok) exq_add({fc | `EXC_FLAG, `EXC_BAD_VALUE, 16'h0}, 2, 1, 1);
      else if (sl != 0 && fc == `FC_RW_MULTI)
         for (k = 0; k < rc; k++) exq_add({sh[rs + k], 16'h0}, 2, k == rc - 1, 1);
      else if (sl != 0) exq_add(0, 2, 1, 0);
      req(sl, fc, (fc == `FC_WR_SINGLE) ? ws : {8'h0, rs}, rc, ws, wc, wq[0]);
   endtask
   task rd(input [7:0] fc, input [15:0] a, input [7:0] n);
      integer k;
      if (n > 125) exq_add({fc | `EXC_FLAG, `EXC_BAD_VALUE, 16'h0}, 2, 1, 1);
      else for (k = 0; k < n; k++) exq_add({sh[a + k], 16'h0}, 2, k == n - 1, 1);
      req(ID, fc, a, n, 0, 0, 0);
   endtask
   task done_t(input string s);
      integer k;
      k = 0;
      while ((exq.size() != 0 || req_ready_o !== 1'b1) && k < 3000) begin
         @(negedge clock_i);
         k++;
      end
      $display("test %s finished", s);
   endtask
   task give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clock_i);
      arst_n_i = 1;
      wr(ID, `FC_WR_MULTI, 0, 120, 0, 0);
      wr(ID, `FC_WR_MULTI, 0, 121, 0, 0);
      for (i = 120; i < 125; i++) wr(ID, `FC_WR_SINGLE, i, 1, 0, 0);
      rd(`FC_RD_HOLD, 0, 125);
      rd(`FC_RD_INPUT, 0, 125);
      rd(`FC_RD_INPUT, 3, 126);
      done_t("reads and writes");
      wr(ID, `FC_RW_MULTI, 130, 118, 130, 118);
      wr(ID, `FC_RW_MULTI, 130, 119, 130, 2);
      done_t("read-write");
      req_data_i = $random(seed);
      exq_add({req_data_i, 16'h0}, 2, 1, 1);
      req(ID, `FC_DIAG, `SUB_LOOPBACK, 0, 0, 0, req_data_i);
      diag_reg_i = $random(seed);
      exq_add({diag_reg_i, 16'h0}, 2, 1, 1);
      req(ID, `FC_DIAG, `SUB_DIAG_REG, 0, 0, 0, 0);
      exq_add({8'h88, `EXC_BAD_VALUE, 16'h0}, 2, 1, 1);
      req(ID, `FC_DIAG, 16'h0001, 0, 0, 0, 0);
      exq_add({8'h81, `EXC_BAD_FUNC, 16'h0}, 2, 1, 1);
      req(ID, 8'h01, 0, 1, 0, 0, 0);
      done_t("diagnostics");
      req(`BCAST_ADDR, `FC_RD_HOLD, 0, 2, 0, 0, 0);
      req(`BCAST_ADDR, `FC_DIAG, `SUB_LOOPBACK, 0, 0, 0, 16'h1234);
      wr(`BCAST_ADDR, `FC_WR_SINGLE, 7, 1, 0, 0);
      wr(`BCAST_ADDR, `FC_WR_MULTI, 10, 4, 10, 0);
      rd(`FC_RD_HOLD, 5, 9);
      done_t("broadcast");
      float_i = 1;
      for (i = 0; i < 4; i++) begin
         byte_order_i = i;
         exq_add(ord(i, {sh[20], sh[21]}), 4, 1, 1);
         req(ID, `FC_RD_HOLD, 20, 2, 0, 0, 0);
         done_t("float order");
      end
      // integers send byte 0 first under the low-byte-first order 0-1-2-3
      float_i = 0;
      byte_order_i = 2'b01;
      exq_add({sh[20][7:0], sh[20][15:8], 16'h0}, 2, 1, 1);
      req(ID, `FC_RD_HOLD, 20, 1, 0, 0, 0);
      done_t("integer order");
      `CHECK("notes left", 0, exq.size())
      give_verdict;
   end
endmodule // tb_mb_request_handler
